// ==== pkg/rlcp_regs.svh ====
/*
  Register offsets, field positions, reset values and link timing counts
  for the remote link command port.
  Assumes it is included by bare name wherever the constants are used.
*/
`ifndef RLCP_REGS_SVH
`define RLCP_REGS_SVH

// Register offsets on the host address bus (low thirteen bits)
`define RLCP_OFS_CTRL      13'h1000
`define RLCP_OFS_CTRL_RSV  13'h1002
`define RLCP_OFS_CMD       13'h1004
`define RLCP_OFS_CMD_EXT   13'h1006
`define RLCP_OFS_DATA_LO   13'h1008
`define RLCP_OFS_DATA_HI   13'h1ffe

// Link control word fields
`define RLCP_CTRL_WD_DIS   0
`define RLCP_CTRL_PWR_EN   1
`define RLCP_CTRL_CCLK_EN  2
`define RLCP_CTRL_CLK_EN   3
`define RLCP_CTRL_POWERED  5
`define RLCP_CTRL_CABLE_B  7
`define RLCP_CTRL_TSEL_LO  8
`define RLCP_CTRL_RESET    16'h0000

// Command word fields
`define RLCP_CMD_DIRTY     15
`define RLCP_CMD_TMO       14
`define RLCP_CMD_RESET     16'h0000

// Command codes
`define RLCP_CC_RESET      3'h0
`define RLCP_CC_END        3'h1
`define RLCP_CC_WREG       3'h2
`define RLCP_CC_RREG       3'h3
`define RLCP_CC_WSTR       3'h4
`define RLCP_CC_NOP_A      3'h5
`define RLCP_CC_NOP_B      3'h6
`define RLCP_CC_RSTR       3'h7

// Watchdog limits in link clock cycles
`define RLCP_WD_SHORT      11'h040
`define RLCP_WD_MID        11'h080
`define RLCP_WD_LONG       11'h400

`endif

// ==== pkg/rlcp_pkg.sv ====
/*
  Types for the remote link command port.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rlcp_pkg;

  // What a link transaction carries
  typedef enum logic [1:0] {
    RLCP_K_CMD,
    RLCP_K_WR,
    RLCP_K_RD
  } rlcp_kind_e;

  // Words handed from host side to link side, held while busy
  typedef struct packed {
    rlcp_kind_e  kind;
    logic [15:0] cmd;
    logic [15:0] data;
  } rlcp_xfer_s;

  // Answer handed back from link side
  typedef struct packed {
    logic [15:0] rdata;
    logic        tmo;
  } rlcp_resp_s;

  // Link side sequencer
  typedef enum {
    RLCP_LK_IDLE,
    RLCP_LK_REQ,
    RLCP_LK_DROP
  } rlcp_lstate_e;

endpackage

// ==== hdl/rlcp_top.sv ====
/*
  Remote link command port: host register port plus link-side sequencer.
  Assumes host strobes are synchronous to sys_clk_in, remote link logic
  runs on link_clk_in, and cable/power status pins are asynchronous.
*/
// Operation
// - Host command write sets the dirty flag, read back at bit 15.
// - Remote acknowledging reset or stream-end clears the dirty flag.
// - Data write under register-write, or read under register-read, clears dirty.
// - Remote power loss or cable disconnect sets the dirty flag.
// - Enabled watchdog flags timeout after 64, 128 or 1024 link cycles.
// - Remote not powered sets the timeout flag at bit 14.
// - Host command write clears the timeout flag first, unless the remote is unpowered or a timeout returns that cycle.
// - Command bits 13 to 3 are the index sent as remote address.
// - All 16 written bits go out; readback shows flags at top bits.
// - Code 000 resets the remote; code 001 ends a stream.
// - Code 010 writes, 011 reads remote register at index low six bits.
// - Code 100 streams toward remote; code 111 streams from remote.
// - Codes 101 and 110 are sent as no-operation only.
// - Reserved command extension ignores writes and reads zero.
// - Data port serves register and stream reads and writes.
// - Data port answers at every even address of its range.
// - Watchdog disable bit inhibits timeouts; watchdog enabled by default.
// - Cable clock driven only while its enable bit is set; off at reset.
`timescale 1ns/1ps
`include "rlcp_regs.svh"
`default_nettype none

module rlcp_top
  import rlcp_pkg::*;
(
  // System clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  // Host register port
  input  wire logic        host_cs_b_in,
  input  wire logic        host_mr_in,
  input  wire logic [12:0] host_address_low_in,
  input  wire logic        host_wr_in,
  input  wire logic        host_rd_in,
  input  wire logic [15:0] host_wdata_in,
  output logic      [15:0] host_rdata_out,
  // Status pins, asynchronous; remote power enable from the control word
  input  wire logic        cable_detect_b_in,
  input  wire logic        remote_powered_in,
  output logic             remote_power_en_out,
  // Link side, on the link clock
  input  wire logic        link_clk_in,
  input  wire logic        link_ack_in,
  input  wire logic [15:0] link_rdata_in,
  output logic             link_req_out,
  output logic      [1:0]  link_kind_out,
  output logic      [15:0] link_cmd_out,
  output logic      [15:0] link_data_out,
  output logic             cable_link_clock_out
);

  // Host side state
  logic [15:0] ctrl_r;
  logic [15:0] cmd_r;
  logic [15:0] data_r;
  logic        dirty_r;
  logic        tmo_r;
  logic        busy_r;
  logic        pend_cmd_r;
  logic        pend_rd_r;
  logic        req_tgl_r;
  rlcp_xfer_s  xfer_r;
  logic        cab_s1_r, cab_s2_r, pwr_s1_r, pwr_s2_r;
  logic        dn_s1_r, dn_s2_r, dn_s3_r;

  // Link side state
  rlcp_lstate_e lst_r;
  logic        rq_s1_r, rq_s2_r, rq_s3_r;
  logic        wd_s1_r, wd_s2_r;
  logic [1:0]  ts_s1_r, ts_s2_r;
  logic        ce_s1_r, ce_s2_r, ce_neg_r;
  logic [10:0] wd_cnt_r;
  logic        done_tgl_r;
  rlcp_resp_s  resp_r;
  rlcp_xfer_s  lk_x_r;

  // Host decode
  logic        reg_sel, cmd_wr, ctrl_wr, data_wr, data_rd, done_ev, lost;
  logic [2:0]  code;
  logic [15:0] rd_mux;

  // Loose decode of the data window, even addresses only
  function automatic logic is_data(input logic [12:0] a);
    is_data = (a >= `RLCP_OFS_DATA_LO) && (a <= `RLCP_OFS_DATA_HI) &&
              !a[0];
  endfunction

  // Watchdog limit from the select field
  function automatic logic [10:0] wd_limit(input logic [1:0] sel);
    unique case (sel)
      2'h0:    wd_limit = `RLCP_WD_SHORT;
      2'h1:    wd_limit = `RLCP_WD_MID;
      default: wd_limit = `RLCP_WD_LONG;
    endcase
  endfunction

  // Access strobes; register space only when both selects are low
  assign reg_sel = !host_cs_b_in && !host_mr_in;
  assign cmd_wr  = reg_sel && host_wr_in &&
                   (host_address_low_in == `RLCP_OFS_CMD);
  assign ctrl_wr = reg_sel && host_wr_in &&
                   (host_address_low_in == `RLCP_OFS_CTRL);
  assign data_wr = reg_sel && host_wr_in && is_data(host_address_low_in);
  assign data_rd = reg_sel && host_rd_in && is_data(host_address_low_in);
  assign code    = cmd_r[2:0];
  assign done_ev = dn_s2_r ^ dn_s3_r;
  assign lost    = !pwr_s2_r || cab_s2_r;

  // Status pin synchronisers
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      cab_s1_r <= 1'b1;
      cab_s2_r <= 1'b1;
      pwr_s1_r <= 1'b0;
      pwr_s2_r <= 1'b0;
    end
    else
    begin
      cab_s1_r <= cable_detect_b_in;
      cab_s2_r <= cab_s1_r;
      pwr_s1_r <= remote_powered_in;
      pwr_s2_r <= pwr_s1_r;
    end

  // Completion toggle back from the link side; third flop is edge history
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      dn_s1_r <= 1'b0;
      dn_s2_r <= 1'b0;
      dn_s3_r <= 1'b0;
    end
    else
    begin
      dn_s1_r <= done_tgl_r;
      dn_s2_r <= dn_s1_r;
      dn_s3_r <= dn_s2_r;
    end

  // Link control word stores all written bits; readback shows live status bits instead
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
    if (!rst_b_in)
      ctrl_r <= `RLCP_CTRL_RESET;
    else if (ctrl_wr)
      ctrl_r <= host_wdata_in;

  // Command word keeps all 16 written bits; it goes out as written
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
    if (!rst_b_in)
      cmd_r <= `RLCP_CMD_RESET;
    else if (cmd_wr)
      cmd_r <= host_wdata_in;

  // Dirty flag: set wins over any clear in the same cycle
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
    if (!rst_b_in)
      dirty_r <= 1'b0;
    else if (cmd_wr || lost)
      dirty_r <= 1'b1;
    else if ((done_ev && xfer_r.kind == RLCP_K_CMD && !resp_r.tmo &&
              (xfer_r.cmd[2:0] == `RLCP_CC_RESET ||
               xfer_r.cmd[2:0] == `RLCP_CC_END)) ||
             (data_wr && code == `RLCP_CC_WREG) ||
             (data_rd && code == `RLCP_CC_RREG))
      dirty_r <= 1'b0;

  // Timeout flag: watchdog result or unpowered remote beat the clear
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
    if (!rst_b_in)
      tmo_r <= 1'b0;
    else if ((done_ev && resp_r.tmo) || !pwr_s2_r)
      tmo_r <= 1'b1;
    else if (cmd_wr)
      tmo_r <= 1'b0;

  // Data word: host writes, or link read results
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
    if (!rst_b_in)
      data_r <= 16'h0000;
    else if (done_ev && xfer_r.kind == RLCP_K_RD)
      data_r <= resp_r.rdata;
    else if (data_wr && !busy_r)
      data_r <= host_wdata_in;

  // Deferred launches; a command written while busy goes out afterwards
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      pend_cmd_r <= 1'b0;
      pend_rd_r  <= 1'b0;
    end
    else
    begin
      if (cmd_wr)
        pend_cmd_r <= 1'b1;
      else if (!busy_r)
        pend_cmd_r <= 1'b0;
      // Reads prefetch after a read command, and per stream read
      if ((done_ev && xfer_r.kind == RLCP_K_CMD && !resp_r.tmo &&
           (xfer_r.cmd[2:0] == `RLCP_CC_RREG ||
            xfer_r.cmd[2:0] == `RLCP_CC_RSTR)) ||
          (data_rd && code == `RLCP_CC_RSTR))
        pend_rd_r <= 1'b1;
      else if (!busy_r && !pend_cmd_r)
        pend_rd_r <= 1'b0;
    end

  // Launch a transaction; the words stay still until completion returns
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      busy_r    <= 1'b0;
      req_tgl_r <= 1'b0;
      xfer_r    <= '{RLCP_K_CMD, 16'h0000, 16'h0000};
    end
    else if (busy_r)
    begin
      if (done_ev)
        busy_r <= 1'b0;
    end
    else if (pend_cmd_r)
    begin
      busy_r    <= 1'b1;
      req_tgl_r <= !req_tgl_r;
      xfer_r    <= '{RLCP_K_CMD, cmd_r, data_r};
    end
    else if (pend_rd_r)
    begin
      busy_r    <= 1'b1;
      req_tgl_r <= !req_tgl_r;
      xfer_r    <= '{RLCP_K_RD, cmd_r, data_r};
    end
    else if (data_wr &&
             (code == `RLCP_CC_WREG || code == `RLCP_CC_WSTR))
    begin
      busy_r    <= 1'b1;
      req_tgl_r <= !req_tgl_r;
      xfer_r    <= '{RLCP_K_WR, cmd_r, host_wdata_in};
    end

  // Readback mux; flags hide the top two written command bits
  always_comb
  begin
    rd_mux = 16'h0000;
    if (host_address_low_in == `RLCP_OFS_CTRL)
    begin
      rd_mux = {6'h00, ctrl_r[`RLCP_CTRL_TSEL_LO+1:`RLCP_CTRL_TSEL_LO],
                8'h00};
      rd_mux[`RLCP_CTRL_CABLE_B] = cab_s2_r;
      rd_mux[`RLCP_CTRL_POWERED] = pwr_s2_r;
      rd_mux[3:0]                = ctrl_r[3:0];
    end
    else if (host_address_low_in == `RLCP_OFS_CMD)
      rd_mux = {dirty_r, tmo_r, cmd_r[13:0]};
    else if (is_data(host_address_low_in))
      rd_mux = data_r;
    // Reserved words and unmapped addresses stay zero
  end

  // Read data lands one cycle after the strobe
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
    if (!rst_b_in)
      host_rdata_out <= 16'h0000;
    else if (reg_sel && host_rd_in)
      host_rdata_out <= rd_mux;

  assign remote_power_en_out = ctrl_r[`RLCP_CTRL_PWR_EN];

  // Link side: request toggle and control levels cross in
  always_ff @(posedge link_clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      rq_s1_r <= 1'b0;
      rq_s2_r <= 1'b0;
      rq_s3_r <= 1'b0;
      wd_s1_r <= 1'b0;
      wd_s2_r <= 1'b0;
      ts_s1_r <= 2'h0;
      ts_s2_r <= 2'h0;
      ce_s1_r <= 1'b0;
      ce_s2_r <= 1'b0;
    end
    else
    begin
      rq_s1_r <= req_tgl_r;
      rq_s2_r <= rq_s1_r;
      rq_s3_r <= rq_s2_r;
      wd_s1_r <= ctrl_r[`RLCP_CTRL_WD_DIS];
      wd_s2_r <= wd_s1_r;
      ts_s1_r <= ctrl_r[`RLCP_CTRL_TSEL_LO+1:`RLCP_CTRL_TSEL_LO];
      ts_s2_r <= ts_s1_r;
      ce_s1_r <= ctrl_r[`RLCP_CTRL_CCLK_EN];
      ce_s2_r <= ce_s1_r;
    end

  // Enable changes while the clock is low, so the gated clock is clean
  always_ff @(negedge link_clk_in or negedge rst_b_in)
    if (!rst_b_in)
      ce_neg_r <= 1'b0;
    else
      ce_neg_r <= ce_s2_r;

  assign cable_link_clock_out = link_clk_in && ce_neg_r;

  // Link sequencer: request, wait for ack or watchdog, wait for ack low
  always_ff @(posedge link_clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      lst_r      <= RLCP_LK_IDLE;
      lk_x_r     <= '{RLCP_K_CMD, 16'h0000, 16'h0000};
      link_req_out <= 1'b0;
      wd_cnt_r   <= 11'h000;
      resp_r     <= '{16'h0000, 1'b0};
      done_tgl_r <= 1'b0;
    end
    else
    begin
      unique case (lst_r)
        RLCP_LK_IDLE:
          if (rq_s2_r ^ rq_s3_r)
          begin
            lk_x_r       <= xfer_r; // Stable while host side is busy
            link_req_out <= 1'b1;
            wd_cnt_r     <= 11'h000;
            lst_r        <= RLCP_LK_REQ;
          end
        RLCP_LK_REQ:
          if (link_ack_in)
          begin
            resp_r       <= '{link_rdata_in, 1'b0};
            link_req_out <= 1'b0;
            lst_r        <= RLCP_LK_DROP;
          end
          else if (!wd_s2_r &&
                   wd_cnt_r == wd_limit(ts_s2_r) - 11'h001)
          begin
            resp_r       <= '{16'h0000, 1'b1};
            link_req_out <= 1'b0;
            lst_r        <= RLCP_LK_DROP;
          end
          else if (!wd_s2_r)
            wd_cnt_r <= wd_cnt_r + 11'h001;
        RLCP_LK_DROP:
          if (!link_ack_in)
          begin
            done_tgl_r <= !done_tgl_r;
            lst_r      <= RLCP_LK_IDLE;
          end
      endcase
    end

  // Link words come from flops held for the whole transaction
  assign link_kind_out = lk_x_r.kind;
  assign link_cmd_out  = lk_x_r.cmd;
  assign link_data_out = lk_x_r.data;

endmodule

`default_nettype wire

// ==== test/rlcp_sva.sv ====
/* Checker for the remote link command port.
   Bound to rlcp_top; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module rlcp_sva
  import rlcp_pkg::*;
(
  // Clocks, reset, host port and status pins
  input wire logic        sys_clk_in,
  input wire logic        rst_b_in,
  input wire logic        link_clk_in,
  input wire logic        host_cs_b_in,
  input wire logic        host_mr_in,
  input wire logic [12:0] host_address_low_in,
  input wire logic        host_wr_in,
  input wire logic        host_rd_in,
  input wire logic [15:0] host_wdata_in,
  input wire logic [15:0] host_rdata_out,
  input wire logic        remote_powered_in,
  input wire logic        cable_detect_b_in,
  // Link port
  input wire logic        link_ack_in,
  input wire logic        link_req_out,
  input wire logic [1:0]  link_kind_out,
  input wire logic [15:0] link_cmd_out,
  input wire logic [15:0] link_data_out
);
  logic        wd_off_r;
  logic [1:0]  tsel_r;
  logic [13:0] cw_r;
  logic [10:0] hi_r;
  wire         rd = !host_cs_b_in && !host_mr_in && host_rd_in;
  wire         wr = !host_cs_b_in && !host_mr_in && host_wr_in;
  wire  [12:0] adr = host_address_low_in;
  wire  [10:0] lim = tsel_r[1] ? 11'h400 : tsel_r[0] ? 11'h080 : 11'h040;
  // Shadow of watchdog controls and of the last command word
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
    if (!rst_b_in)
      {wd_off_r, tsel_r, cw_r} <= 17'h00000;
    else if (wr && adr == 13'h1000)
      {wd_off_r, tsel_r} <= {host_wdata_in[0], host_wdata_in[9:8]};
    else if (wr && adr == 13'h1004)
      cw_r <= host_wdata_in[13:0];
  // Link edges with request up; valid only while the watchdog runs
  always_ff @(posedge link_clk_in or negedge rst_b_in)
    if (!rst_b_in)
      hi_r <= 11'h000;
    else
      hi_r <= link_req_out ? hi_r + 11'h001 : 11'h000;
  sequence s_cmd_wr;
    wr && adr == 13'h1004 && remote_powered_in && !cable_detect_b_in;
  endsequence
  sequence s_cmd_rd;
    rd && adr == 13'h1004;
  endsequence
  a_cmd_back: assert property (
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    s_cmd_wr ##3 s_cmd_rd |=> host_rdata_out == {2'h2, cw_r})
    else $error("command readback wrong");
  a_ext_zero: assert property (
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    rd && adr == 13'h1006 |=> host_rdata_out == 16'h0000)
    else $error("reserved word not zero");
  a_odd_zero: assert property (
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    rd && adr[0] |=> host_rdata_out == 16'h0000)
    else $error("odd address not zero");
  a_rdata_stands: assert property (
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    !rd |=> $stable(host_rdata_out))
    else $error("read data moved without a read");
  a_word_stable: assert property (
    @(posedge link_clk_in) disable iff (!rst_b_in)
    link_req_out |=> $stable({link_kind_out, link_cmd_out, link_data_out}))
    else $error("link words moved during request");
  a_ack_drop: assert property (
    @(posedge link_clk_in) disable iff (!rst_b_in)
    link_req_out && link_ack_in |=> !link_req_out)
    else $error("request held after ack");
  a_wait_ack: assert property (
    @(posedge link_clk_in) disable iff (!rst_b_in)
    !link_req_out && link_ack_in |=> !link_req_out)
    else $error("request before ack fell");
  a_wd_limit: assert property (
    @(posedge link_clk_in) disable iff (!rst_b_in)
    link_req_out && !wd_off_r |-> hi_r <= lim)
    else $error("request outlived watchdog");
endmodule
bind rlcp_top rlcp_sva u_sva (.*);
`default_nettype wire

// ==== test/rlcp_remote.sv ====
/* Remote machine model at the far end of the link.
   Assumes the four-phase req/ack handshake on the link clock. */
`timescale 1ns/1ps
`default_nettype none
module rlcp_remote
  import rlcp_pkg::*;
(
  // Link clock, reset and behaviour selects
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        slow_in,
  input  wire logic        mute_in,
  // Link
  input  wire logic        req_in,
  input  wire logic [1:0]  kind_in,
  input  wire logic [15:0] cmd_in,
  input  wire logic [15:0] data_in,
  output logic             ack_out,
  output logic      [15:0] rdata_out,
  output int               n_out
);
  logic [15:0] rf [64];
  int          dly;
  // Answer each request unless muted, promptly or a few edges late
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      ack_out <= 1'b0;
      rdata_out <= 16'h0000;
      dly <= 0;
      n_out <= 0;
      foreach (rf[i]) rf[i] <= 16'h0000;
    end
    else if (req_in && !ack_out && !mute_in)
    begin
      dly <= dly + 1;
      if (dly >= (slow_in ? 5 : 0))
      begin
        ack_out <= 1'b1;
        n_out <= n_out + 1;
        dly <= 0;
        if (kind_in == RLCP_K_WR) rf[cmd_in[8:3]] <= data_in;
        rdata_out <= rf[cmd_in[8:3]];
      end
    end
    else if (!req_in && ack_out)
    begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out; // Released lines lose the word
    end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
/* Self-checking bench for the remote link command port.
   Assumes the remote model and the bound checker are compiled too. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rlcp_pkg::*;
  logic        sys_clk_in = 1'b0;
  logic        link_clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        host_cs_b_in = 1'b1;
  logic        host_mr_in = 1'b1;
  logic [12:0] host_address_low_in = 13'h0000;
  logic        host_wr_in = 1'b0;
  logic        host_rd_in = 1'b0;
  logic [15:0] host_wdata_in = 16'h0000;
  logic        cable_detect_b_in = 1'b1;
  logic        remote_powered_in = 1'b0;
  logic        slow = 1'b0;
  logic        mute = 1'b0;
  wire         link_ack_in, link_req_out, remote_power_en_out;
  wire         cable_link_clock_out;
  wire  [1:0]  link_kind_out;
  wire  [15:0] host_rdata_out, link_rdata_in, link_cmd_out, link_data_out;
  int          n_ack, error_cnt = 0, n_tests = 0;
  logic [31:0] seed = 32'h691a;
  logic [15:0] v, c, last;
  logic [12:0] ra [3] = '{13'h1006, 13'h1002, 13'h1009};
  rlcp_top dut (.*);
  rlcp_remote u_rem (.clk_in(link_clk_in), .rst_b_in(rst_b_in),
    .slow_in(slow), .mute_in(mute), .req_in(link_req_out),
    .kind_in(link_kind_out), .cmd_in(link_cmd_out),
    .data_in(link_data_out), .ack_out(link_ack_in),
    .rdata_out(link_rdata_in), .n_out(n_ack));
  // Two clocks with no phase relation
  initial forever #50 sys_clk_in = ~sys_clk_in;
  initial
  begin
    #37;
    forever #62.5 link_clk_in = ~link_clk_in;
  end
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One register cycle; read data is settled when it returns
  task automatic acc(logic w, logic [12:0] a, logic [15:0] d);
    @(negedge sys_clk_in);
    {host_cs_b_in, host_mr_in, host_wr_in, host_rd_in} = {2'h0, w, !w};
    host_address_low_in = a;
    host_wdata_in = d;
    @(negedge sys_clk_in);
    {host_cs_b_in, host_mr_in, host_wr_in, host_rd_in} = 4'hc;
    host_wdata_in = ~d;
    @(negedge sys_clk_in);
  endtask
  // Bounded wait for one more remote answer, then for flags to return
  task automatic tx_wait();
    int n0;
    n0 = n_ack;
    for (int i = 0; i < 400 && n_ack == n0; i++) @(negedge sys_clk_in);
    chk("transfer", n_ack != n0, 16'h1);
    repeat (30) @(negedge sys_clk_in);
  endtask
  task automatic clk_seen(logic exp);
    logic s;
    s = 1'b0;
    // Enable has to cross into the link domain before the gate follows it
    repeat (4) @(negedge sys_clk_in);
    repeat (16) @(negedge sys_clk_in) s |= cable_link_clock_out;
    chk("cable clock", s, exp);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard, far beyond the expected run
  initial
  begin
    #2000000;
    error_cnt++;
    give_verdict();
  end
  // Main sequence
  initial
  begin
    repeat (4) @(negedge sys_clk_in);
    rst_b_in = 1'b1;
    repeat (6) @(negedge sys_clk_in);
    acc(0, 13'h1004, 16'h0);
    chk("absent flags", rdat_top(), 16'hc000);
    clk_seen(1'b0);
    {cable_detect_b_in, remote_powered_in} = 2'h1;
    acc(1, 13'h1000, 16'h0006);
    acc(0, 13'h1000, 16'h0);
    chk("control", host_rdata_out, 16'h0026);
    chk("power en", remote_power_en_out, 16'h1);
    clk_seen(1'b1);
    v = rnd();
    for (int k = 0; k < 8; k++)
    begin
      slow = ^rnd();
      c = {v[15:3], k[2:0]};
      acc(1, 13'h1004, c);
      tx_wait();
      chk("link cmd", link_cmd_out, c);
      if (k == 2 || k == 4)
      begin
        last = rnd();
        acc(1, 13'h1ffe - {2'h0, last[10:1], 1'b0}, last);
        tx_wait();
        chk("link data", link_data_out, last);
        chk("link kind", link_kind_out, 16'h1);
      end
      if (k == 3 || k == 7)
      begin
        acc(0, k == 3 ? 13'h1008 : 13'h1ffe, 16'h0);
        chk("read data", host_rdata_out, last);
      end
      acc(0, 13'h1004, 16'h0);
      chk("cmd word", host_rdata_out, {k > 3, 1'b0, c[13:0]});
    end
    foreach (ra[i])
    begin
      acc(1, ra[i], 16'hffff);
      acc(0, ra[i], 16'h0);
      chk("reserved", host_rdata_out, 16'h0000);
    end
    // Let the last stream prefetch finish before the remote goes quiet
    repeat (40) @(negedge sys_clk_in);
    mute = 1'b1;
    for (int t = 0; t < 3; t++)
    begin
      acc(1, 13'h1000, {6'h0, t[1:0], 8'h06});
      acc(1, 13'h1004, 16'h0005);
      acc(0, 13'h1004, 16'h0);
      chk("tmo cleared", host_rdata_out, 16'h8005);
      repeat ((t == 2 ? 1024 : 64 << t) * 5 / 4 - 12) @(negedge sys_clk_in);
      acc(0, 13'h1004, 16'h0);
      chk("tmo early", host_rdata_out, 16'h8005);
      repeat (30) @(negedge sys_clk_in);
      acc(0, 13'h1004, 16'h0);
      chk("tmo late", host_rdata_out, 16'hc005);
    end
    acc(1, 13'h1000, 16'h0007);
    acc(1, 13'h1004, 16'h0006);
    repeat (120) @(negedge sys_clk_in);
    acc(0, 13'h1004, 16'h0);
    chk("wd off", host_rdata_out, 16'h8006);
    {mute, slow} = 2'h1;
    tx_wait();
    acc(1, 13'h1000, 16'h0000);
    cable_detect_b_in = 1'b1;
    clk_seen(1'b0);
    acc(0, 13'h1004, 16'h0);
    chk("unplugged", host_rdata_out & 16'h8000, 16'h8000);
    give_verdict();
  end
  function automatic logic [15:0] rdat_top();
    return host_rdata_out & 16'hc000;
  endfunction
endmodule
`default_nettype wire
